// *** design/see_top.sv ***
/*
  Serial command port of a 16-bit word non-volatile memory with a
  self-timed programming cycle. Pins are sampled by I_CLK.
  Assumes serial clock much slower than I_CLK and a host obeying frame timing.
*/
`timescale 1ns/1ns
`include "see_cfg.svh"
module see_top #(
  parameter int ADDR_BITS = `SEE_ADDR_BITS,
  parameter int WORDS = `SEE_WORDS,
  parameter int PROG_CYCLES = `SEE_PROG_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Serial command pins
  input wire logic I_CHIP_SELECT,
  input wire logic I_SERIAL_CLOCK,
  input wire logic I_SERIAL_IN,
  // Serial output pin, enable low while driven
  output logic O_SERIAL_OUT,
  output logic O_SERIAL_OUT_OE_B
);
  import see_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_b;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  logic [2:0] pins;
  see_sync #(.WIDTH(3)) u_sync (
    .clk(I_CLK),
    .rst_b(rst_b),
    .i_async({I_CHIP_SELECT, I_SERIAL_CLOCK, I_SERIAL_IN}),
    .o_sync(pins)
  );
  logic cs, sck, sin;
  assign cs = pins[2];
  assign sck = pins[1];
  assign sin = pins[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int FRAME = 3 + ADDR_BITS;
  localparam int FULL = FRAME + `SEE_DATA_BITS;
  typedef struct packed {
    see_state_type st;
    see_prog_type pg;
    logic sck_prev;
    logic enabled;
    logic [5:0] cnt;
    logic [1:0] op;
    logic [ADDR_BITS-1:0] addr;
    logic [15:0] shreg;
    logic [31:0] timer;
    logic dout;
    logic oe_b;
  } see_regs_type;

  see_regs_type r_q, r_d;
  logic [15:0] mem [WORDS];
  logic sck_rise;
  assign sck_rise = sck & ~r_q.sck_prev;

  function automatic logic [1:0] sub_code(input logic [ADDR_BITS-1:0] a);
    sub_code = a[ADDR_BITS-1 -: 2];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.sck_prev = sck;
    unique case (r_q.st)
      SEE_IDLE: begin
        // Outside a frame a raised select shows ready, so a poll after a
        // finished or refused programming command needs no saved status.
        r_d.oe_b = ~cs;
        r_d.dout = 1'b1;
        r_d.cnt = 6'h0;
        if (cs && sck_rise && sin) begin
          r_d.st = SEE_SHIFT;
          r_d.cnt = 6'h1;
          r_d.oe_b = 1'b1;
        end
      end
      SEE_SHIFT: begin
        if (!cs) begin
          r_d.st = SEE_IDLE;
          if (r_q.pg != SEE_PG_NONE) begin
            r_d.st = SEE_PROGRAM;
            r_d.timer = 32'(PROG_CYCLES);
          end
        end else if (sck_rise && r_q.pg == SEE_PG_NONE) begin
          r_d.cnt = r_q.cnt + 6'h1;
          if (r_q.cnt < 6'h3) begin
            r_d.op = {r_q.op[0], sin};
          end else if (r_q.cnt < 6'(FRAME)) begin
            r_d.addr = {r_q.addr[ADDR_BITS-2:0], sin};
          end else begin
            r_d.shreg = {r_q.shreg[14:0], sin};
          end
          if (r_d.cnt == 6'(FRAME)) begin
            unique case (r_q.op)
              `SEE_OP_READ: begin
                r_d.shreg = mem[r_d.addr % WORDS];
                r_d.st = SEE_READOUT;
              end
              `SEE_OP_ERASE: begin
                r_d.shreg = 16'hffff;
                r_d.pg = r_q.enabled ? SEE_PG_WORD : SEE_PG_NONE;
                if (!r_q.enabled) r_d.st = SEE_WAIT_DESEL;
              end
              `SEE_OP_WRITE: ;
              default: begin
                unique case (sub_code(r_d.addr))
                  `SEE_SUB_ENABLE: begin
                    r_d.enabled = 1'b1;
                    r_d.st = SEE_WAIT_DESEL;
                  end
                  `SEE_SUB_DISABLE: begin
                    r_d.enabled = 1'b0;
                    r_d.st = SEE_WAIT_DESEL;
                  end
                  `SEE_SUB_ERALL: begin
                    r_d.shreg = 16'hffff;
                    r_d.pg = r_q.enabled ? SEE_PG_ALL : SEE_PG_NONE;
                    if (!r_q.enabled) r_d.st = SEE_WAIT_DESEL;
                  end
                  default: ;
                endcase
              end
            endcase
          end
          if (r_d.cnt == 6'(FULL)) begin
            if (r_q.op == `SEE_OP_WRITE) r_d.pg = r_q.enabled ? SEE_PG_WORD : SEE_PG_NONE;
            else r_d.pg = r_q.enabled ? SEE_PG_ALL : SEE_PG_NONE;
            if (!r_q.enabled) r_d.st = SEE_WAIT_DESEL;
          end
        end
      end
      SEE_READOUT: begin
        if (!cs) begin
          r_d.st = SEE_IDLE;
          r_d.oe_b = 1'b1;
        end else if (r_q.oe_b) begin
          r_d.oe_b = 1'b0;
          r_d.dout = 1'b0;
        end else if (sck_rise) begin
          r_d.dout = r_q.shreg[15];
          r_d.shreg = {r_q.shreg[14:0], 1'b0};
        end
      end
      SEE_WAIT_DESEL: begin
        if (!cs) r_d.st = SEE_IDLE;
      end
      SEE_PROGRAM: begin
        r_d.pg = SEE_PG_NONE;
        if (r_q.timer != 32'h0) r_d.timer = r_q.timer - 32'h1;
        if (cs) begin
          r_d.oe_b = 1'b0;
          r_d.dout = (r_q.timer == 32'h0);
        end else begin
          r_d.oe_b = 1'b1;
        end
        if (r_q.timer == 32'h0 && !cs) r_d.st = SEE_IDLE;
      end
      default: r_d.st = SEE_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{st: SEE_IDLE, pg: SEE_PG_NONE, enabled: 1'b0, oe_b: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Array update at the start of the programming cycle
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (r_q.st == SEE_SHIFT && !cs && r_q.pg == SEE_PG_WORD) begin
      mem[r_q.addr % WORDS] <= r_q.shreg;
    end else if (r_q.st == SEE_SHIFT && !cs && r_q.pg == SEE_PG_ALL) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= r_q.shreg;
    end
  end

  assign O_SERIAL_OUT = r_q.dout;
  assign O_SERIAL_OUT_OE_B = r_q.oe_b;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_b);
  release_desel_a: assert property (!cs && r_q.st != SEE_PROGRAM |=> O_SERIAL_OUT_OE_B)
    else $error("output driven while deselected");
  busy_low_a: assert property (r_q.st == SEE_PROGRAM && r_q.timer > 32'h1 && cs |=> !O_SERIAL_OUT)
    else $error("ready shown during programming");
  start_prog_a: assert property (r_q.st == SEE_SHIFT && !cs && r_q.pg != SEE_PG_NONE |=> r_q.st == SEE_PROGRAM)
    else $error("programming not started");
  locked_no_prog_a: assert property (!r_q.enabled |=> r_q.pg == SEE_PG_NONE)
    else $error("programming queued while locked");
  idle_ready_a: assert property (r_q.st == SEE_IDLE && cs && !sck_rise |=> O_SERIAL_OUT && !O_SERIAL_OUT_OE_B)
    else $error("ready not shown while idle");
  enable_set_a: assert property (r_q.st == SEE_SHIFT && r_d.cnt == 6'(FRAME) && sck_rise && cs
    && r_q.op == `SEE_OP_EXT && sub_code(r_d.addr) == `SEE_SUB_ENABLE |=> r_q.enabled)
    else $error("enable not taken");
  disable_set_a: assert property (r_q.st == SEE_SHIFT && r_d.cnt == 6'(FRAME) && sck_rise && cs
    && r_q.op == `SEE_OP_EXT && sub_code(r_d.addr) == `SEE_SUB_DISABLE |=> !r_q.enabled)
    else $error("disable not taken");
  dummy_zero_a: assert property (r_q.st == SEE_READOUT && r_q.oe_b && cs |=> !O_SERIAL_OUT && !O_SERIAL_OUT_OE_B)
    else $error("dummy bit not zero");
  start_bit_a: assert property (r_q.st == SEE_IDLE && sck_rise && !sin |=> r_q.st == SEE_IDLE)
    else $error("frame begun without start bit");
  read_cov: cover property (r_q.st == SEE_READOUT ##1 r_q.st == SEE_IDLE);
  prog_cov: cover property (r_q.st == SEE_PROGRAM && r_q.timer == 32'h0 && cs);
  enable_cov: cover property (!r_q.enabled ##1 r_q.enabled);
endmodule

// *** design/see_cfg.svh ***
/*
  Constants for the serial word memory command port: opcodes, frame lengths,
  command sub-codes and programming time.
  Assumes it is included by the package and the design modules by bare name.
*/
// Functional notes
// - Input bits taken on serial_clock rising edge.
// - Frame is start bit, opcode, address.
// - Output shows ready 1, busy 0.
// - Programming disabled after reset.
// - program_enable_cmd unlocks erase and write.
// - program_disable_cmd locks erase and write.
// - Read sends dummy zero then 16 bits.
// - Read works whether locked or not.
// - Erase sets addressed word to ones.
// - erase_all_cmd sets whole array to ones.
// - Write programs word, data MSB first.
// - write_all_cmd programs whole array with data.
// - Unused upper address bits are ignored.
// - Programming starts when select falls.
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH
`define SEE_OP_EXT 2'h0
`define SEE_OP_WRITE 2'h1
`define SEE_OP_READ 2'h2
`define SEE_OP_ERASE 2'h3
`define SEE_SUB_DISABLE 2'h0
`define SEE_SUB_WRALL 2'h1
`define SEE_SUB_ERALL 2'h2
`define SEE_SUB_ENABLE 2'h3
`define SEE_DATA_BITS 16
`define SEE_ADDR_BITS 6
`define SEE_WORDS 64
`define SEE_CLK_MHZ 250
`define SEE_PROG_TIME_US 10000
`define SEE_PROG_CYCLES (`SEE_PROG_TIME_US * `SEE_CLK_MHZ)
`endif

// *** design/see_pkg.sv ***
/*
  Types for the serial word memory command port.
  Assumes see_cfg.svh is on the include path.
*/
package see_pkg;
  `include "see_cfg.svh"
  typedef enum logic [2:0] {
    SEE_IDLE,
    SEE_SHIFT,
    SEE_READOUT,
    SEE_WAIT_DESEL,
    SEE_PROGRAM
  } see_state_type;
  typedef enum logic [2:0] {
    SEE_PG_NONE,
    SEE_PG_WORD,
    SEE_PG_ALL
  } see_prog_type;
endpackage

// *** design/see_sync.sv ***
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ns
module see_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// *** tb/see_host.sv ***
/*
  Host model for the serial command port: drives select, serial clock and
  serial data in, and samples serial data out.
  Assumes clk is the bench's 250 MHz clock; the serial clock is about 8 MHz.
*/
`timescale 1ns/1ns
module see_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe_b,
  output logic cs,
  output logic sk,
  output logic di
);
  // ----------------------------------------
  // Serial frame tasks
  // ----------------------------------------
  initial begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
  end

  // Data is set while the serial clock is low and taken on its rise.
  task automatic tick(input logic b, output logic q);
    di <= b;
    repeat (15) @(posedge clk);
    q = sdo_oe_b ? 1'bx : sdo;
    sk <= 1'b1;
    repeat (16) @(posedge clk);
    sk <= 1'b0;
  endtask

  // Sends the low n bits MSB first; the last 17 samples come back in rd.
  task automatic frame(input int n, input logic [26:0] bits, output logic [16:0] rd);
    logic q;
    rd = 17'h0;
    cs <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      tick(bits[i], q);
      rd = {rd[15:0], q};
    end
    cs <= 1'b0;
    // The line is not left at its last value once the frame is over.
    di <= ~di;
    repeat (70) @(posedge clk);
  endtask

  // Raises select and counts cycles until ready is shown.
  task automatic poll(output int n);
    cs <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge clk);
      if (sdo_oe_b === 1'b0 && sdo === 1'b1) begin
        break;
      end
    end
    cs <= 1'b0;
    repeat (70) @(posedge clk);
  endtask
endmodule

// *** tb/serial_eeprom_command_port_tb.sv ***
/*
  Self-checking bench for the serial command port.
  Assumes see_top, see_host and see_cfg.svh; programming shortened to 200 cycles.
*/
`timescale 1ns/1ns
`include "see_cfg.svh"
module serial_eeprom_command_port_tb;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cs, sk, di, so, so_oe_b;
  int err_count = 0;
  int n_tests = 0;

  always #2 i_clk = ~i_clk;

  see_top #(.PROG_CYCLES(200)) dut (
    .I_CLK(i_clk), .I_RST_B(i_rst_b), .I_CHIP_SELECT(cs), .I_SERIAL_CLOCK(sk),
    .I_SERIAL_IN(di), .O_SERIAL_OUT(so), .O_SERIAL_OUT_OE_B(so_oe_b));
  see_host host (.clk(i_clk), .sdo(so), .sdo_oe_b(so_oe_b), .cs(cs), .sk(sk), .di(di));

  // ----------------------------------------
  // Checks and commands
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // A refused command shows ready at once; a real one stays busy a while.
  task automatic wait_ready(input int lo, input int hi, input string m);
    int n;
    host.poll(n);
    n_tests++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("[ERR] %0t %s ready after %0d cycles", $time, m, n);
      if (n >= 1000) begin
        end_of_test();
      end
    end
  endtask

  task automatic ext(input logic [1:0] sub, input logic [15:0] d, input int n);
    logic [16:0] r;
    host.frame(n, 27'({1'b1, `SEE_OP_EXT, sub, 4'h0, d} >> (25 - n)), r);
  endtask

  task automatic word(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d, input int n);
    logic [16:0] r;
    host.frame(n, 27'({1'b1, op, a, d} >> (25 - n)), r);
  endtask

  task automatic rd_word(input logic [5:0] a, input logic [15:0] exp, input string m);
    logic [16:0] r;
    host.frame(26, 27'({1'b1, `SEE_OP_READ, a, 17'h0}), r);
    chk(r, {1'b0, exp}, m);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_locked();
    word(`SEE_OP_WRITE, 6'h05, 16'h1111, 25);
    wait_ready(0, 20, "write after reset");
  endtask

  task automatic t_write();
    ext(`SEE_SUB_ENABLE, 16'h0, 9);
    word(`SEE_OP_WRITE, 6'h05, 16'ha5c3, 25);
    wait_ready(50, 400, "write busy");
    rd_word(6'h05, 16'ha5c3, "read word");
  endtask

  task automatic t_disable();
    ext(`SEE_SUB_DISABLE, 16'h0, 9);
    word(`SEE_OP_WRITE, 6'h05, 16'h0000, 25);
    wait_ready(0, 20, "locked write");
    ext(`SEE_SUB_ERALL, 16'h0, 9);
    wait_ready(0, 20, "locked erase all");
    word(`SEE_OP_ERASE, 6'h05, 16'h0, 9);
    wait_ready(0, 20, "locked erase");
    ext(`SEE_SUB_WRALL, 16'h0000, 25);
    wait_ready(0, 20, "locked write all");
    rd_word(6'h05, 16'ha5c3, "read locked");
  endtask

  task automatic t_erase();
    ext(`SEE_SUB_ENABLE, 16'h0, 9);
    word(`SEE_OP_ERASE, 6'h05, 16'h0, 9);
    wait_ready(50, 400, "erase busy");
    rd_word(6'h05, 16'hffff, "erase word");
  endtask

  task automatic t_all();
    ext(`SEE_SUB_WRALL, 16'h1234, 25);
    wait_ready(50, 400, "write all busy");
    rd_word(6'h00, 16'h1234, "write all low");
    rd_word(6'h3f, 16'h1234, "write all high");
    ext(`SEE_SUB_ERALL, 16'h0, 9);
    wait_ready(50, 400, "erase all busy");
    rd_word(6'h09, 16'hffff, "erase all");
  endtask

  task automatic t_abort();
    word(`SEE_OP_WRITE, 6'h00, 16'hab00, 17);
    chk({16'h0, so_oe_b}, 17'h1, "output released");
    wait_ready(0, 20, "short frame");
    rd_word(6'h00, 16'hffff, "short frame kept");
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (10) @(posedge i_clk);
    t_locked();
    t_write();
    t_disable();
    t_erase();
    t_all();
    t_abort();
    end_of_test();
  end
endmodule
